// ---- fpc_dev.sv ----
// Behaviour
// - Request low aborts user mode, restarts load
// - Status low through power-on delay
// - Load-complete low until whole image received
// - Config clock ignored once configuration done
// - Data width by mode; lines released after
// - Load-complete rises only after error-free image
// - Host gives two falling edges after done
// - Init-done output low until init finishes
// - Load-complete low within 600 ns of request
// - Status low within 600 ns of request
// - Host holds request low at least 2 us
// - Status low between 268 and 1506 us
// - Status released within 1506 us of request
// - Unwatched status: wait 1506 us before clocking
// - Watched status: wait 2 us after rise
// - Words captured on rising config clock edge
// - Ratio one unless decompression or security
// - Ratio N: data held N-1 periods
// - Clock at most 125 or 100 MHz
// - Internal oscillator: user mode 175-437 us
// - User clock: 4 periods then 8576 edges
module fpc_dev (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Link
  fpc_link_if.dev                          lnk,
  // Mode and image setup
  input  wire fpc_pkg::fpc_width_t         width,
  input  wire logic [fpc_pkg::RATIO_W-1:0] ratio,
  input  wire logic                        feat_on,
  input  wire logic [fpc_pkg::LEN_W-1:0]   image_len,
  // Initialisation options
  input  wire logic                        init_done_en,
  input  wire logic                        use_user_clk,
  input  wire logic                        user_init_clock,
  // Received words
  output logic [fpc_pkg::DATA_W-1:0]       word_data,
  output logic                             word_valid,
  // Status
  output logic                             init_done_oe,
  output logic                             user_mode,
  output logic                             cfg_err
);
  import fpc_pkg::*;

  typedef enum logic [5:0] {
    D_RST  = 6'h01,
    D_STAT = 6'h02,
    D_LOAD = 6'h04,
    D_TAIL = 6'h08,
    D_INIT = 6'h10,
    D_USER = 6'h20
  } fpc_dst_t;

  fpc_dst_t           st_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [UCNT_W-1:0]  ucnt_r;
  logic [RATIO_W-1:0] sub_r;
  logic [LEN_W-1:0]   words_r;
  logic [1:0]         falls_r;
  logic [DATA_W-1:0]  word_r;
  logic               wvld_r;
  logic               err_r;
  logic               all_in;

  // ==========================================================
  // Synchronisers; data shares the clock's two-stage delay
  logic               req_s1, req_s2;
  logic               stat_s1, stat_s2;
  logic               cclk_s1, cclk_s2, cclk_s3;
  logic               uclk_s1, uclk_s2, uclk_s3;
  logic [DATA_W-1:0]  data_s1, data_s2;
  logic               c_rise, c_fall, u_rise;

  always_ff @(posedge core_clk) begin
    req_s1  <= lnk.req_n;
    req_s2  <= req_s1;
    stat_s1 <= lnk.stat;
    stat_s2 <= stat_s1;
    data_s1 <= lnk.data;
    data_s2 <= data_s1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cclk_s1 <= 1'b0;
      cclk_s2 <= 1'b0;
      cclk_s3 <= 1'b0;
      uclk_s1 <= 1'b0;
      uclk_s2 <= 1'b0;
      uclk_s3 <= 1'b0;
    end else begin
      cclk_s1 <= lnk.cclk;
      cclk_s2 <= cclk_s1;
      cclk_s3 <= cclk_s2;
      uclk_s1 <= user_init_clock;
      uclk_s2 <= uclk_s1;
      uclk_s3 <= uclk_s2;
    end
  end

  assign c_rise = cclk_s2 & ~cclk_s3;
  assign c_fall = ~cclk_s2 & cclk_s3;
  assign u_rise = uclk_s2 & ~uclk_s3;

  // ==========================================================
  // Pins; both lines are open drain, so only enables are driven
  // Three stages from request pin to enable fit within six cycles
  assign lnk.stat_dev_oe = (st_r == D_RST) || (st_r == D_STAT);
  assign lnk.done_dev_oe = (st_r == D_RST) || (st_r == D_STAT) || (st_r == D_LOAD);
  assign init_done_oe    = init_done_en && ((st_r == D_TAIL) || (st_r == D_INIT));
  assign user_mode       = (st_r == D_USER);
  assign word_data       = word_r;
  assign word_valid      = wvld_r;
  assign cfg_err         = err_r;
  // Whole image counted and the last word's clock group closed
  assign all_in          = (words_r == image_len) && (sub_r == '0);

  // ==========================================================
  // Configuration sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Reset stands for power-up: the status low phase starts here
      st_r    <= D_STAT;
      cnt_r   <= '0;
      ucnt_r  <= '0;
      sub_r   <= '0;
      words_r <= '0;
      falls_r <= '0;
    end else if (!req_s2) begin
      st_r  <= D_RST;
      cnt_r <= '0;
    end else begin
      case (st_r)
        D_RST: begin
          st_r  <= D_STAT;
          cnt_r <= cnt_r + 1'b1;
        end
        D_STAT: begin
          // Minimum low time is used as the release point, well under the maximum
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= CNT_W'(STATUS_MIN_CYC - 1)) begin
            st_r    <= D_LOAD;
            sub_r   <= '0;
            words_r <= '0;
          end
        end
        D_LOAD: begin
          // A status line still held low by the host blocks capture
          if (c_rise && stat_s2 && !err_r && !all_in) begin
            sub_r <= (sub_r == fpc_ratio(ratio) - 1'b1) ? '0 : sub_r + 1'b1;
            if (sub_r == '0) begin
              words_r <= words_r + 1'b1;
            end
          end
          // Release waits for the fall closing the last word group, so the
          // host's own clock falls are never mistaken for tail edges
          if (c_fall && all_in) begin
            st_r    <= D_TAIL;
            falls_r <= '0;
          end
        end
        D_TAIL: begin
          if (c_fall) begin
            falls_r <= falls_r + 1'b1;
            if (falls_r == 2'(TAIL_FALLS - 1)) begin
              st_r   <= D_INIT;
              cnt_r  <= '0;
              ucnt_r <= '0;
            end
          end
        end
        D_INIT: begin
          if (use_user_clk) begin
            if (cnt_r < CNT_W'(CD2CU_CYC)) begin
              cnt_r <= cnt_r + 1'b1;
            end else if (u_rise) begin
              ucnt_r <= ucnt_r + 1'b1;
              if (ucnt_r == UCNT_W'(USR_INIT_PERIODS - 1)) begin
                st_r <= D_USER;
              end
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == CNT_W'(CD2UM_CYC - 1)) begin
              st_r <= D_USER;
            end
          end
        end
        D_USER: st_r <= D_USER;
        default: st_r <= D_STAT;
      endcase
    end
  end

  // ==========================================================
  // Word capture, masked to the selected width
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_r <= '0;
      wvld_r <= 1'b0;
    end else begin
      wvld_r <= 1'b0;
      if (st_r == D_LOAD && req_s2 && c_rise && stat_s2 && !err_r &&
          sub_r == '0 && !all_in) begin
        word_r <= data_s2 & fpc_mask(width);
        wvld_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Ratio check: compressed or secured images need several clocks per word
  // An error freezes loading so load-complete never rises
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (!req_s2) begin
      err_r <= 1'b0;
    end else if (st_r == D_STAT && feat_on && fpc_ratio(ratio) == 3'h1) begin
      err_r <= 1'b1;
    end
  end
endmodule

// ---- fpc_host.sv ----
module fpc_host #(
  parameter int CF2CK_CYC_P = fpc_pkg::CF2CK_CYC
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Link
  fpc_link_if.host                        lnk,
  // Control
  input  wire logic                       start,
  input  wire logic                       watch_stat,
  input  wire logic                       hold_stat,
  input  wire fpc_pkg::fpc_width_t        width,
  input  wire logic [fpc_pkg::RATIO_W-1:0] ratio,
  input  wire logic [fpc_pkg::LEN_W-1:0]  image_len,
  // Word source
  input  wire logic [fpc_pkg::DATA_W-1:0] word_in,
  input  wire logic                       word_vld,
  output logic                            word_rdy,
  // Status
  output logic                            busy,
  output logic                            finished
);
  import fpc_pkg::*;

  typedef enum logic [6:0] {
    H_IDLE  = 7'h01,
    H_REQ   = 7'h02,
    H_WAIT  = 7'h04,
    H_FETCH = 7'h08,
    H_SEND  = 7'h10,
    H_DONE  = 7'h20,
    H_TAIL  = 7'h40
  } fpc_hst_t;

  fpc_hst_t           st_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [PH_W-1:0]    ph_r;
  logic [RATIO_W-1:0] per_r;
  logic [LEN_W-1:0]   words_r;
  logic [1:0]         falls_r;
  logic               req_n_r;
  logic               cclk_r;
  logic               oe_r;
  logic [DATA_W-1:0]  data_r;
  logic               fin_r;
  logic               stat_s1, stat_s2, done_s1, done_s2;
  logic               ph_hi, ph_end;

  assign lnk.req_n        = req_n_r;
  assign lnk.cclk         = cclk_r;
  assign lnk.data         = data_r;
  assign lnk.data_oe      = oe_r;
  assign lnk.stat_host_oe = hold_stat;
  assign word_rdy         = (st_r == H_FETCH);
  assign busy             = (st_r != H_IDLE);
  assign finished         = fin_r;

  // ==========================================================
  // Synchronisers
  always_ff @(posedge core_clk) begin
    stat_s1 <= lnk.stat;
    stat_s2 <= stat_s1;
    done_s1 <= lnk.done;
    done_s2 <= done_s1;
  end

  assign ph_hi  = (ph_r == PH_W'(CCLK_HALF_CYC - 1));
  assign ph_end = (ph_r == PH_W'(2 * CCLK_HALF_CYC - 1));

  // ==========================================================
  // Sequencer; the clock stays low outside SEND and TAIL
  always_ff @(posedge core_clk) begin
    fin_r <= 1'b0;
    if (rst) begin
      st_r    <= H_IDLE;
      cnt_r   <= '0;
      ph_r    <= '0;
      per_r   <= '0;
      words_r <= '0;
      falls_r <= '0;
      req_n_r <= 1'b1;
      cclk_r  <= 1'b0;
      oe_r    <= 1'b0;
      data_r  <= '0;
    end else begin
      case (st_r)
        H_IDLE: begin
          if (start) begin
            st_r    <= H_REQ;
            req_n_r <= 1'b0;
            cnt_r   <= '0;
          end
        end
        H_REQ: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(CFG_CYC - 1)) begin
            req_n_r <= 1'b1;
            cnt_r   <= '0;
            st_r    <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (watch_stat) begin
            cnt_r <= stat_s2 ? cnt_r + 1'b1 : '0;
            if (stat_s2 && cnt_r >= CNT_W'(ST2CK_CYC)) begin
              st_r <= H_FETCH;
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r >= CNT_W'(CF2CK_CYC_P)) begin
              st_r <= H_FETCH;
            end
          end
          words_r <= '0;
        end
        H_FETCH: begin
          if (word_vld) begin
            data_r <= word_in & fpc_mask(width);
            oe_r   <= 1'b1;
            ph_r   <= '0;
            per_r  <= '0;
            st_r   <= H_SEND;
          end
        end
        H_SEND: begin
          // Half period of 4 core cycles keeps the clock far below both limits
          ph_r <= ph_r + 1'b1;
          if (ph_hi) begin
            cclk_r <= 1'b1;
          end
          if (ph_end) begin
            cclk_r <= 1'b0;
            ph_r   <= '0;
            if (per_r == fpc_ratio(ratio) - 1'b1) begin
              words_r <= words_r + 1'b1;
              st_r    <= (words_r == image_len - 1'b1) ? H_DONE : H_FETCH;
            end else begin
              per_r <= per_r + 1'b1;
            end
          end
        end
        H_DONE: begin
          if (done_s2) begin
            ph_r    <= '0;
            falls_r <= '0;
            oe_r    <= 1'b0;
            st_r    <= H_TAIL;
          end
        end
        H_TAIL: begin
          ph_r <= ph_r + 1'b1;
          if (ph_hi) begin
            cclk_r <= 1'b1;
          end
          if (ph_end) begin
            cclk_r  <= 1'b0;
            ph_r    <= '0;
            falls_r <= falls_r + 1'b1;
            if (falls_r == 2'(TAIL_FALLS - 1)) begin
              st_r  <= H_IDLE;
              fin_r <= 1'b1;
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
  // the user clock is not the host's; the device counts its rises during initialisation
endmodule

// ---- fpc_link_if.sv ----
interface fpc_link_if;
  import fpc_pkg::*;
  logic              req_n;
  logic              cclk;
  logic [DATA_W-1:0] data;
  logic              data_oe;
  logic              stat_dev_oe;
  logic              stat_host_oe;
  logic              done_dev_oe;
  logic              stat;
  logic              done;

  // Open-drain lines with pull-ups: any enable pulls the line low
  assign stat = ~(stat_dev_oe | stat_host_oe);
  assign done = ~done_dev_oe;

  modport dev (
    input  req_n, cclk, data, data_oe, stat, done,
    output stat_dev_oe, done_dev_oe
  );
  modport host (
    output req_n, cclk, data, data_oe, stat_host_oe,
    input  stat, done
  );
endinterface

// ---- fpc_link_sva.sv ----
// ==========================================================
// Link checker
module fpc_link_sva (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        rst,
  // Link
  input wire logic                        req_n,
  input wire logic                        cclk,
  input wire logic [fpc_pkg::DATA_W-1:0]  data,
  input wire logic                        data_oe,
  input wire logic                        stat_dev_oe,
  input wire logic                        stat_host_oe,
  input wire logic                        done_dev_oe,
  input wire logic                        stat,
  input wire logic                        done
);
  timeunit 1ns;
  timeprecision 1ns;
  import fpc_pkg::*;
  // Slack for the request synchroniser inside the device
  localparam int LOW_MIN = STATUS_MIN_CYC - 4;
  localparam int LOW_MAX = CF2CK_CYC;
  logic [15:0] since_r;
  logic [15:0] hi_r;
  logic [7:0]  lo_r;
  logic [1:0]  tail_r;
  logic        rises_r;
  logic        req_q_r;
  logic        cclk_q_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Helper counters
  always_ff @(posedge core_clk) begin
    req_q_r  <= req_n;
    cclk_q_r <= cclk;
  end
  always_ff @(posedge core_clk) begin
    if (rst || (req_q_r && !req_n)) since_r <= 16'h0000;
    else if (since_r != 16'hFFFF) since_r <= since_r + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    if (rst || !stat) hi_r <= 16'h0000;
    else if (hi_r != 16'hFFFF) hi_r <= hi_r + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    if (rst || req_n) lo_r <= 8'h00;
    else if (lo_r != 8'hFF) lo_r <= lo_r + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (rst || !req_n) rises_r <= 1'b0;
    else if (cclk && !cclk_q_r) rises_r <= 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (rst || !done) tail_r <= 2'h0;
    else if (!cclk && cclk_q_r && tail_r != 2'h3) tail_r <= tail_r + 2'h1;
  end

  // ==========================================================
  // Properties
  a_done_low_fast: assert property ($fell(req_n) |-> ##[0:6] done_dev_oe)
    else $error("load-complete not pulled low after request");
  a_stat_low_fast: assert property ($fell(req_n) |-> ##[0:6] stat_dev_oe)
    else $error("status not pulled low after request");
  a_stat_low_window: assert property ($fell(stat_dev_oe) |-> since_r inside {[LOW_MIN:LOW_MAX]})
    else $error("status low time out of range");
  a_req_low_min: assert property ($rose(req_n) |-> lo_r >= CFG_CYC)
    else $error("request pulse too short");
  a_clk_after_stat: assert property ($rose(cclk) |-> hi_r >= ST2CK_CYC)
    else $error("config clock rose too soon after status");
  a_clk_idle_req: assert property (!req_n |-> !cclk && !data_oe)
    else $error("clock or data active during request");
  a_data_stable_edge: assert property ($rose(cclk) |-> $stable(data) ##1 $stable(data))
    else $error("data changed around rising clock");
  a_done_after_words: assert property ($fell(done_dev_oe) |-> rises_r && stat && req_n)
    else $error("load-complete released without words");
  a_done_with_stat: assert property (stat_dev_oe && req_n |-> done_dev_oe)
    else $error("load-complete high while status low");
  a_tail_two_falls: assert property (done |-> tail_r <= 2'h2)
    else $error("more than two tail falls");
  a_tail_in_time: assert property ($rose(done) |-> ##[1:40] tail_r == 2'h2)
    else $error("tail falls missing");

  c_done_rise: cover property ($rose(done));
  c_reconfig: cover property ($fell(req_n) ##[1:40] $rose(req_n));
  c_stat_held: cover property ($fell(stat_dev_oe) && stat_host_oe);
endmodule

// ---- fpc_pkg.sv ----
package fpc_pkg;
  // ==========================================================
  // Clocks and widths
  localparam int CORE_CLK_NS    = 100;
  localparam int CCLK_PERIOD_NS = 800;
  localparam int CCLK_HALF_CYC  = CCLK_PERIOD_NS / (2 * CORE_CLK_NS);
  localparam int DATA_W         = 32;
  localparam int LEN_W          = 16;
  localparam int RATIO_W        = 3;
  localparam int CNT_W          = 16;
  localparam int UCNT_W         = 14;
  localparam int PH_W           = 3;

  // ==========================================================
  // Timing, time in its own unit, then cycles of core_clk
  localparam int T_REQ2LOW_NS   = 600;
  localparam int REQ2LOW_CYC    = T_REQ2LOW_NS / CORE_CLK_NS;
  localparam int T_CFG_US       = 2;
  localparam int CFG_CYC        = (T_CFG_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int T_STATUS_MIN_US = 268;
  localparam int STATUS_MIN_CYC = (T_STATUS_MIN_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int T_CF2CK_US     = 1506;
  localparam int CF2CK_CYC      = (T_CF2CK_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int T_ST2CK_US     = 2;
  localparam int ST2CK_CYC      = (T_ST2CK_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int T_CD2UM_MIN_US = 175;
  localparam int CD2UM_CYC      = (T_CD2UM_MIN_US * 1000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int CD2CU_PERIODS  = 4;
  localparam int CD2CU_CYC      = CD2CU_PERIODS * CCLK_PERIOD_NS / CORE_CLK_NS;
  localparam int USR_INIT_PERIODS = 8576;
  localparam int TAIL_FALLS     = 2;

  // ==========================================================
  // Word width modes
  typedef enum logic [1:0] {
    FPC_W8  = 2'h0,
    FPC_W16 = 2'h1,
    FPC_W32 = 2'h2
  } fpc_width_t;

  function automatic logic [DATA_W-1:0] fpc_mask(input fpc_width_t w);
    case (w)
      FPC_W8:  fpc_mask = 32'h0000_00FF;
      FPC_W16: fpc_mask = 32'h0000_FFFF;
      default: fpc_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [RATIO_W-1:0] fpc_ratio(input logic [RATIO_W-1:0] r);
    fpc_ratio = (r == 3'h0) ? 3'h1 : r;
  endfunction
endpackage

// ---- tb_top.sv ----
module tb_top import fpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // Blind wait just above the device's status release, to keep runs short
  localparam int BLIND    = 2800;
  localparam int UCLK_CYC = 4;
  localparam int UM_MAX   = 4370;
  logic                 core_clk = 1'b0;
  logic                 rst      = 1'b1;
  logic                 ucl      = 1'b0;
  logic                 start    = 1'b0;
  logic                 watch    = 1'b1;
  logic                 hold     = 1'b0;
  logic                 feat     = 1'b0;
  logic                 ide      = 1'b0;
  logic                 uuc      = 1'b0;
  logic                 word_vld = 1'b1;
  fpc_width_t           width    = FPC_W8;
  logic [RATIO_W-1:0]   ratio    = 3'h1;
  logic [LEN_W-1:0]     len      = 16'h0001;
  logic [DATA_W-1:0]    word_in  = 32'h0000_0000;
  logic [DATA_W-1:0]    word_data;
  logic                 word_rdy, busy, finished, word_valid, init_oe, user_mode, cfg_err;
  logic [DATA_W-1:0]    rx[$];
  int                   mismatches = 0;
  int                   cmp_count  = 0;
  int                   sent       = 0;
  int                   fin_cnt    = 0;

  always #50 core_clk = ~core_clk;
  always #200 ucl = ~ucl;

  fpc_link_if lnk ();
  fpc_host #(.CF2CK_CYC_P(BLIND)) i_fpc_host (.core_clk(core_clk), .rst(rst), .lnk(lnk),
    .start(start), .watch_stat(watch), .hold_stat(hold), .width(width), .ratio(ratio),
    .image_len(len), .word_in(word_in), .word_vld(word_vld), .word_rdy(word_rdy),
    .busy(busy), .finished(finished));
  fpc_dev i_fpc_dev (.core_clk(core_clk), .rst(rst), .lnk(lnk), .width(width),
    .ratio(ratio), .feat_on(feat), .image_len(len), .init_done_en(ide),
    .use_user_clk(uuc), .user_init_clock(ucl), .word_data(word_data),
    .word_valid(word_valid), .init_done_oe(init_oe), .user_mode(user_mode),
    .cfg_err(cfg_err));
  fpc_link_sva i_fpc_link_sva (.core_clk(core_clk), .rst(rst), .req_n(lnk.req_n),
    .cclk(lnk.cclk), .data(lnk.data), .data_oe(lnk.data_oe),
    .stat_dev_oe(lnk.stat_dev_oe), .stat_host_oe(lnk.stat_host_oe),
    .done_dev_oe(lnk.done_dev_oe), .stat(lnk.stat), .done(lnk.done));

  // ==========================================================
  // Word source and capture
  function automatic logic [DATA_W-1:0] pat(input int k);
    pat = 32'h9E37_79B9 * (k + 1);
  endfunction
  always @(posedge core_clk) begin
    if (word_vld && word_rdy) sent++;
    if (word_valid) rx.push_back(word_data);
    if (finished) fin_cnt++;
  end
  always @(negedge core_clk) word_in = pat(sent);

  // ==========================================================
  // Shared tasks
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: cond = !busy;
      1: cond = user_mode;
      2: cond = lnk.done;
      3: cond = !lnk.req_n;
      4: cond = lnk.stat;
      default: cond = (sent >= len);
    endcase
  endfunction
  task automatic wt(input int s, input int lim, output int n);
    n = 0;
    while (cond(s) !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (cond(s) !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, 1'b0, 1'b1);
      stop_test();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_power;
    int n;
    repeat (STATUS_MIN_CYC - 10) @(negedge core_clk);
    chk(lnk.stat, 1'b0);
    chk(lnk.done, 1'b0);
    wt(4, 20, n);
    $display("test power-on finished");
  endtask
  task automatic t_load(input fpc_width_t w, input logic [2:0] r, input logic f, ws, h, ie,
                        uu, input logic [15:0] n);
    int c;
    logic [31:0] m;
    width = w;
    ratio = r;
    feat = f;
    watch = ws;
    ide = ie;
    uuc = uu;
    len = n;
    fin_cnt = 0;
    rx.delete();
    sent = 0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    wt(3, 10, c);
    repeat (6) @(negedge core_clk);
    chk(lnk.done, 1'b0);
    chk(lnk.stat, 1'b0);
    chk(user_mode, 1'b0);
    if (h) begin
      // Status held from outside well past the device's own release
      hold = 1'b1;
      repeat (STATUS_MIN_CYC + 300) @(negedge core_clk);
      chk(lnk.stat, 1'b0);
      chk(rx.size(), 0);
      hold = 1'b0;
    end
    wt(2, 20000, c);
    chk(rx.size(), n);
    m = (w == FPC_W8) ? 32'h0000_00FF : (w == FPC_W16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    for (int k = 0; k < n; k++) chk(rx[k], pat(k) & m);
    repeat (8) @(negedge core_clk);
    chk(init_oe, ie);
    wt(1, 40000, c);
    if (uu) chk(c + 8 >= 32 + USR_INIT_PERIODS * UCLK_CYC, 1'b1);
    else chk(c + 8 >= CD2UM_CYC && c + 8 <= UM_MAX, 1'b1);
    chk(init_oe, 1'b0);
    chk(cfg_err, 1'b0);
    wt(0, 100, c);
    chk(fin_cnt, 1);
    $display("test load width %0d ratio %0d finished", w, r);
  endtask
  task automatic t_err;
    int c;
    feat = 1'b1;
    ratio = 3'h1;
    width = FPC_W32;
    len = 16'h0003;
    fin_cnt = 0;
    watch = 1'b1;
    rx.delete();
    sent = 0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    wt(5, 20000, c);
    repeat (100) @(negedge core_clk);
    chk(cfg_err, 1'b1);
    chk(lnk.done, 1'b0);
    chk(rx.size(), 0);
    chk(fin_cnt, 0);
    $display("test refused ratio finished");
  endtask

  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_power();
    t_load(FPC_W8, 3'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0005);
    t_load(FPC_W16, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0004);
    t_load(FPC_W32, 3'h3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0003);
    t_err();
    stop_test();
  end
endmodule
